// *** verilog/pif_pkg.sv ***
// ==========================================================================
// shared constants and carriers of the peripheral event flag block
// ==========================================================================
package pif_pkg;

	// ==================================================================
	// bus geometry
	// ==================================================================
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// ==================================================================
	// register byte offsets
	// ==================================================================
	localparam logic [3:0] FLAGS_OFS  = 4'h0;
	localparam logic [3:0] STATUS_OFS = 4'h4;
	localparam logic [3:0] MASK_OFS   = 4'h8;
	localparam logic [3:0] CONFIG_OFS = 4'hc;

	// ==================================================================
	// flag bit positions
	// ==================================================================
	localparam int BIT_PSP  = 7;
	localparam int BIT_ADC  = 6;
	localparam int BIT_RX   = 5;
	localparam int BIT_TX   = 4;
	localparam int BIT_SSP  = 3;
	localparam int BIT_CCP  = 2;
	localparam int BIT_TIMER_TWO_COUNT = 1;
	localparam int BIT_TIMER_ONE_COUNT = 0;

	// software may write these bits; rx and tx follow their buffers only
	localparam logic [7:0] FLAGS_RW_MASK = 8'hcf;

	// ==================================================================
	// configuration fields
	// ==================================================================
	localparam int CFG_SMALL_BIT = 0;
	localparam int CFG_MODE_LSB  = 1;

	// ==================================================================
	// reset values
	// ==================================================================
	localparam logic [7:0] FLAGS_RST  = 8'h00;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST   = 8'h00;
	localparam logic       SMALL_RST  = 1'h0;

	// ==================================================================
	// types
	// ==================================================================
	typedef enum logic [1:0] {
		PIF_CCP_OFF,
		PIF_CCP_CAPTURE,
		PIF_CCP_COMPARE,
		PIF_CCP_PWM
	} pif_ccp_mode_e;

	// one-cycle event pulses from peripheral logic on ref_clk
	typedef struct packed {
		logic psp_access;
		logic adc_done;
		logic rx_loaded;
		logic rx_read;
		logic tx_drained;
		logic tx_written;
		logic ssp_done;
		logic ccp_capture;
		logic ccp_compare;
		logic timer_two_count_match;
		logic timer_one_count_overflow;
	} pif_evt_s;

	// one accepted bus access, valid for exactly one cycle
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        be;
	} pif_req_s;

	// write strobe aimed at one register with its low byte enabled
	function automatic logic reg_wr_hit(input pif_req_s req, input logic [3:0] ofs);
		reg_wr_hit = req.wr && (req.addr == ofs) && req.be[0];
	endfunction

	// read strobe aimed at one register
	function automatic logic reg_rd_hit(input pif_req_s req, input logic [3:0] ofs);
		reg_rd_hit = req.rd && (req.addr == ofs);
	endfunction

endpackage

// *** verilog/pif_flag_cell.sv ***
`timescale 1ns/100ps
// ==========================================================================
// one sticky flag: set wins over clear
// ==========================================================================
module pif_flag_cell (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic set_evt,
	input  wire logic clr_evt,
	output logic      flag
);
	typedef struct packed {
		logic flag;
	} pif_cell_s;

	pif_cell_s st;
	pif_cell_s next_st;

	// an event in the clearing cycle must survive
	always_comb begin
		next_st = st;
		if (set_evt) begin
			next_st.flag = 1'b1;
		end else if (clr_evt) begin
			next_st.flag = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign flag = st.flag;
endmodule

// *** verilog/pif_avalon_slave.sv ***
`timescale 1ns/100ps
// ==========================================================================
// avalon-mm slave front end: one wait state on every access
// ==========================================================================
module pif_avalon_slave (
	input  wire logic                           ref_clk,
	input  wire logic                           srst,
	input  wire logic [pif_pkg::ADDR_W-1:0]     avs_address,
	input  wire logic                           avs_read,
	input  wire logic                           avs_write,
	input  wire logic [pif_pkg::DATA_W-1:0]     avs_writedata,
	input  wire logic [3:0]                     avs_byteenable,
	output logic      [pif_pkg::DATA_W-1:0]     avs_readdata,
	output logic                                avs_waitrequest,
	input  wire logic [pif_pkg::DATA_W-1:0]     rdata_in,
	output pif_pkg::pif_req_s                   req
);
	typedef struct packed {
		logic                       ack;
		logic [pif_pkg::DATA_W-1:0] rdata;
	} pif_slv_s;

	pif_slv_s st;
	pif_slv_s next_st;
	logic     first;

	// the request is taken in its first cycle so side effects fire once
	assign first = (avs_read || avs_write) && !st.ack;

	always_comb begin
		next_st     = st;
		next_st.ack = first;
		if (first && avs_read) begin
			next_st.rdata = rdata_in;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// strobes to the register file
	assign req.rd          = first && avs_read;
	assign req.wr          = first && avs_write;
	assign req.addr        = avs_address;
	assign req.wdata       = avs_writedata;
	assign req.be          = avs_byteenable;
	assign avs_waitrequest = first;
	assign avs_readdata    = st.rdata;
endmodule

// *** verilog/pif_irq_flags.sv ***
`timescale 1ns/100ps
module pif_irq_flags (
	input  wire logic                           ref_clk,
	input  wire logic                           srst,
	input  wire logic [pif_pkg::ADDR_W-1:0]     avs_address,
	input  wire logic                           avs_read,
	input  wire logic                           avs_write,
	input  wire logic [pif_pkg::DATA_W-1:0]     avs_writedata,
	input  wire logic [3:0]                     avs_byteenable,
	output logic      [pif_pkg::DATA_W-1:0]     avs_readdata,
	output logic                                avs_waitrequest,
	input  pif_pkg::pif_evt_s                   events,
	output logic      [7:0]                     peripheral_event_flags_one,
	output logic                                irq
);
	// ==================================================================
	// state
	// ==================================================================
	typedef struct packed {
		logic [7:0]             status;
		logic [7:0]             mask;
		logic                   small_pkg;
		pif_pkg::pif_ccp_mode_e ccp_mode;
		logic                   irq;
	} pif_top_s;

	pif_top_s          st;
	pif_top_s          next_st;
	pif_pkg::pif_req_s req;
	logic [31:0]       rdata;
	logic [7:0]        flags;
	logic [7:0]        hw_set;
	logic [7:0]        set_v;
	logic [7:0]        clr_v;
	logic              flag_wr;
	logic              status_rd;

	// ==================================================================
	// bus front end
	// ==================================================================
	pif_avalon_slave u_slave (
		.ref_clk         (ref_clk),
		.srst            (srst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.rdata_in        (rdata),
		.req             (req)
	);

	assign flag_wr   = pif_pkg::reg_wr_hit(req, pif_pkg::FLAGS_OFS);
	assign status_rd = pif_pkg::reg_rd_hit(req, pif_pkg::STATUS_OFS);

	// ==================================================================
	// hardware set conditions, not gated by mask or any global enable
	// ==================================================================
	always_comb begin
		hw_set                    = 8'h00;
		hw_set[pif_pkg::BIT_PSP]  = events.psp_access && !st.small_pkg;
		hw_set[pif_pkg::BIT_ADC]  = events.adc_done;
		hw_set[pif_pkg::BIT_RX]   = events.rx_loaded;
		hw_set[pif_pkg::BIT_TX]   = events.tx_drained;
		hw_set[pif_pkg::BIT_SSP]  = events.ssp_done;
		// pwm and off modes drop both ccp events
		hw_set[pif_pkg::BIT_CCP]  =
			(st.ccp_mode == pif_pkg::PIF_CCP_CAPTURE && events.ccp_capture) ||
			(st.ccp_mode == pif_pkg::PIF_CCP_COMPARE && events.ccp_compare);
		hw_set[pif_pkg::BIT_TIMER_TWO_COUNT] = events.timer_two_count_match;
		hw_set[pif_pkg::BIT_TIMER_ONE_COUNT] = events.timer_one_count_overflow;
	end

	// ==================================================================
	// set and clear vectors for the flag cells
	// ==================================================================
	always_comb begin
		set_v = hw_set;
		clr_v = 8'h00;
		// software writes act only on the writable bits
		if (flag_wr) begin
			set_v = set_v | (req.wdata[7:0] & pif_pkg::FLAGS_RW_MASK);
			clr_v = ~req.wdata[7:0] & pif_pkg::FLAGS_RW_MASK;
		end
		// buffer flags follow their data register accesses
		clr_v[pif_pkg::BIT_RX] = events.rx_read;
		clr_v[pif_pkg::BIT_TX] = events.tx_written;
		// absent slave port: clear must win here, so block the set
		if (st.small_pkg) begin
			set_v[pif_pkg::BIT_PSP] = 1'b0;
			clr_v[pif_pkg::BIT_PSP] = 1'b1;
		end
	end

	// ==================================================================
	// flag storage
	// ==================================================================
	for (genvar i = 0; i < 8; i++) begin : g_flag
		pif_flag_cell u_cell (
			.ref_clk (ref_clk),
			.srst    (srst),
			.set_evt (set_v[i]),
			.clr_evt (clr_v[i]),
			.flag    (flags[i])
		);
	end

	assign peripheral_event_flags_one = flags;

	// ==================================================================
	// interrupt status, mask, configuration
	// ==================================================================
	always_comb begin
		next_st = st;
		// read clears status, but an event in that cycle is kept
		if (status_rd) begin
			next_st.status = 8'h00;
		end
		next_st.status = next_st.status | hw_set;
		if (pif_pkg::reg_wr_hit(req, pif_pkg::MASK_OFS)) begin
			next_st.mask = req.wdata[7:0];
		end
		if (pif_pkg::reg_wr_hit(req, pif_pkg::CONFIG_OFS)) begin
			next_st.small_pkg = req.wdata[pif_pkg::CFG_SMALL_BIT];
			next_st.ccp_mode  = pif_pkg::pif_ccp_mode_e'(
				req.wdata[pif_pkg::CFG_MODE_LSB +: 2]);
		end
		// registered so the output comes straight from a flop
		next_st.irq = |(next_st.status & next_st.mask);
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			st.status    <= pif_pkg::STATUS_RST;
			st.mask      <= pif_pkg::MASK_RST;
			st.small_pkg <= pif_pkg::SMALL_RST;
			st.ccp_mode  <= pif_pkg::PIF_CCP_OFF;
			st.irq       <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	assign irq = st.irq;

	// ==================================================================
	// read mux; unmapped offsets read zero
	// ==================================================================
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (req.addr)
			pif_pkg::FLAGS_OFS: begin
				rdata[7:0] = flags;
			end
			pif_pkg::STATUS_OFS: begin
				rdata[7:0] = st.status;
			end
			pif_pkg::MASK_OFS: begin
				rdata[7:0] = st.mask;
			end
			pif_pkg::CONFIG_OFS: begin
				rdata[pif_pkg::CFG_SMALL_BIT]     = st.small_pkg;
				rdata[pif_pkg::CFG_MODE_LSB +: 2] = st.ccp_mode;
			end
			default: begin
				rdata = 32'h0000_0000;
			end
		endcase
	end

	// ==================================================================
	// checks
	// ==================================================================
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	// a flag write that drives one bit to zero with no event
	sequence s_wr_zero(int b);
		flag_wr && !req.wdata[b] && !hw_set[b];
	endsequence

	sequence s_wr_one(int b);
		flag_wr && req.wdata[b];
	endsequence

	sequence s_quiet(int b);
		!flag_wr && !hw_set[b];
	endsequence

	// masked-off event still lands in the flag and the status
	a_poll_masked: assert property (
		(events.timer_one_count_overflow && !st.mask[pif_pkg::BIT_TIMER_ONE_COUNT])
		|=> flags[pif_pkg::BIT_TIMER_ONE_COUNT] && st.status[pif_pkg::BIT_TIMER_ONE_COUNT]
		&& (irq == |(st.status & st.mask)))
		else $error("masked event did not set flag");

	a_psp_set: assert property (
		(events.psp_access && !st.small_pkg) |=> flags[pif_pkg::BIT_PSP])
		else $error("slave port access did not set flag");

	a_adc_hold: assert property (
		flags[pif_pkg::BIT_ADC] ##0 s_quiet(pif_pkg::BIT_ADC)
		[*2] |=> flags[pif_pkg::BIT_ADC])
		else $error("conversion flag dropped without software");

	a_rx_follow: assert property (
		(events.rx_read && !events.rx_loaded) |=> !flags[pif_pkg::BIT_RX])
		else $error("receive flag not cleared by buffer read");

	a_rx_set: assert property (
		events.rx_loaded |=> flags[pif_pkg::BIT_RX] && st.status[pif_pkg::BIT_RX])
		else $error("receive buffer load did not set flag");

	a_tx_follow: assert property (
		events.tx_drained |=> flags[pif_pkg::BIT_TX]
		##1 (flags[pif_pkg::BIT_TX] || $past(events.tx_written)))
		else $error("transmit flag lost while buffer empty");

	a_tx_clear: assert property (
		(events.tx_written && !events.tx_drained) |=> !flags[pif_pkg::BIT_TX])
		else $error("transmit flag not cleared by buffer write");

	a_ssp_sticky: assert property (
		events.ssp_done ##1 s_quiet(pif_pkg::BIT_SSP) [*3]
		|=> flags[pif_pkg::BIT_SSP])
		else $error("sync serial flag not sticky");

	a_ccp_capture: assert property (
		(st.ccp_mode == pif_pkg::PIF_CCP_CAPTURE && events.ccp_capture)
		|=> flags[pif_pkg::BIT_CCP] && st.status[pif_pkg::BIT_CCP])
		else $error("capture did not set flag");

	a_ccp_pwm: assert property (
		(st.ccp_mode == pif_pkg::PIF_CCP_PWM && !flag_wr)
		|=> $stable(flags[pif_pkg::BIT_CCP]))
		else $error("flag moved in pwm mode");

	a_timer_two_count_set: assert property (
		events.timer_two_count_match |=> flags[pif_pkg::BIT_TIMER_TWO_COUNT] ##1
		(flags[pif_pkg::BIT_TIMER_TWO_COUNT] || $past(flag_wr, 1)))
		else $error("period match flag not set or not held");

	a_timer_one_count_set: assert property (
		events.timer_one_count_overflow |=> flags[pif_pkg::BIT_TIMER_ONE_COUNT])
		else $error("overflow did not set flag");

	a_psp_absent: assert property (
		st.small_pkg |=> !flags[pif_pkg::BIT_PSP])
		else $error("absent slave port flag reads one");

	a_sw_clear: assert property (
		s_wr_zero(pif_pkg::BIT_SSP) |=> !flags[pif_pkg::BIT_SSP])
		else $error("write of zero did not clear");

	// a software set leaves the status alone: only hardware events reach it
	a_sw_set: assert property (
		s_wr_one(pif_pkg::BIT_TIMER_TWO_COUNT) |=> flags[pif_pkg::BIT_TIMER_TWO_COUNT]
		&& (st.status[pif_pkg::BIT_TIMER_TWO_COUNT] == ($past(st.status[pif_pkg::BIT_TIMER_TWO_COUNT])
		|| $past(hw_set[pif_pkg::BIT_TIMER_TWO_COUNT]))))
		else $error("write of one did not set flag or touched status");

	a_ro_ignore: assert property (
		(flag_wr && !events.rx_loaded && !events.rx_read)
		|=> $stable(flags[pif_pkg::BIT_RX]))
		else $error("read-only flag changed by write");

	a_irq_level: assert property (
		##1 (irq == |(st.status & st.mask)))
		else $error("interrupt output disagrees with status and mask");

	a_bus_answer: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered on second cycle");

	// waitrequest only ever stalls a request that is present
	a_wait_idle: assert property (
		avs_waitrequest |-> (avs_read || avs_write))
		else $error("waitrequest raised with no request");

	// read data is the register as it stood when the read was taken
	a_mask_read: assert property (
		pif_pkg::reg_rd_hit(req, pif_pkg::MASK_OFS)
		|=> (avs_readdata == {24'h000000, $past(st.mask)}))
		else $error("mask read returned wrong data");

	a_mask_write: assert property (
		pif_pkg::reg_wr_hit(req, pif_pkg::MASK_OFS)
		|=> (st.mask == $past(req.wdata[7:0])))
		else $error("mask write did not land");

	// each enabled source sets its flag and its status bit one cycle later
	a_adc_set: assert property (
		events.adc_done |=> flags[pif_pkg::BIT_ADC] && st.status[pif_pkg::BIT_ADC])
		else $error("conversion did not set flag");

	a_ssp_set: assert property (
		events.ssp_done |=> flags[pif_pkg::BIT_SSP] && st.status[pif_pkg::BIT_SSP])
		else $error("sync serial completion did not set flag");

	a_ccp_compare: assert property (
		(st.ccp_mode == pif_pkg::PIF_CCP_COMPARE && events.ccp_compare)
		|=> flags[pif_pkg::BIT_CCP] && st.status[pif_pkg::BIT_CCP])
		else $error("compare match did not set flag");

	// an event in the cycle of a software clear must survive
	a_set_wins: assert property (
		(flag_wr && !req.wdata[pif_pkg::BIT_TIMER_ONE_COUNT] && events.timer_one_count_overflow)
		|=> flags[pif_pkg::BIT_TIMER_ONE_COUNT])
		else $error("event lost against software clear");

	// a write with the low byte lane off changes no flag
	a_be_ignore: assert property (
		(req.wr && !req.be[0] && hw_set == 8'h00 && !events.rx_read
		&& !events.tx_written && !st.small_pkg) |=> $stable(flags))
		else $error("write with low lane off changed flags");

	// status is sticky until read; a read keeps only the events of its own cycle
	a_status_clear: assert property (
		status_rd |=> (st.status == $past(hw_set)))
		else $error("status read did not clear");

	a_status_hold: assert property (
		(st.status[pif_pkg::BIT_ADC] && !status_rd) |=> st.status[pif_pkg::BIT_ADC])
		else $error("status bit dropped without a read");

	a_psp_status: assert property (
		(st.small_pkg && !st.status[pif_pkg::BIT_PSP])
		|=> !st.status[pif_pkg::BIT_PSP])
		else $error("absent slave port raised status");
endmodule

// *** sim/pif_evt_source.sv ***
`timescale 1ns/100ps
// ==========================================================================
// peripheral event sources: one cycle of events per cycle of fire
// ==========================================================================
module pif_evt_source (
	input  wire logic              ref_clk,
	input  wire logic              srst,
	input  wire logic              fire,
	input  wire pif_pkg::pif_evt_s pick,
	output pif_pkg::pif_evt_s      events
);
	// a registered copy of pick for every cycle fire is high, so a held command repeats the events each cycle
	always_ff @(posedge ref_clk) begin
		if (srst || !fire) begin
			events <= '0;
		end else begin
			events <= pick;
		end
	end
endmodule

// *** sim/pif_irq_flags_bench.sv ***
`timescale 1ns/100ps
// ==========================================================================
// self-checking bench of the peripheral event flag block
// ==========================================================================
module pif_irq_flags_bench;
	logic              ref_clk;
	logic              srst;
	logic [3:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	pif_pkg::pif_evt_s events;
	pif_pkg::pif_evt_s pick;
	logic              fire;
	logic [7:0]        flags;
	logic              irq;
	logic [31:0]       rdat;
	logic [3:0]        be_val;
	int                n_errors;
	int                total_checks;

	pif_irq_flags DUT (
		.ref_clk                    (ref_clk),
		.srst                       (srst),
		.avs_address                (avs_address),
		.avs_read                   (avs_read),
		.avs_write                  (avs_write),
		.avs_writedata              (avs_writedata),
		.avs_byteenable             (avs_byteenable),
		.avs_readdata               (avs_readdata),
		.avs_waitrequest            (avs_waitrequest),
		.events                     (events),
		.peripheral_event_flags_one (flags),
		.irq                        (irq)
	);

	pif_evt_source SRC (
		.ref_clk (ref_clk),
		.srst    (srst),
		.fire    (fire),
		.pick    (pick),
		.events  (events)
	);

	// ==================================================================
	// clock, reset and inputs at time zero
	// ==================================================================
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		srst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		pick = '0;
		fire = 1'b0;
		be_val = 4'hf;
		n_errors = 0;
		total_checks = 0;
	end

	// ==================================================================
	// shared tasks
	// ==================================================================
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// request held through every rising edge until waitrequest is sampled low there
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be_val;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge ref_clk);
		end
		// read data stands at the completing edge; one idle edge before the next request
		rdat = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input string name, input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(name, exp, rdat);
	endtask

	// one event pulse, then long enough for the flag to land
	task automatic pulse(input logic [10:0] p);
		fire <= 1'b1;
		pick <= pif_pkg::pif_evt_s'(p);
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	// ==================================================================
	// scenarios
	// ==================================================================
	task automatic t_reset;
		rd("flags", pif_pkg::FLAGS_OFS, 32'h0);
		rd("status", pif_pkg::STATUS_OFS, 32'h0);
		rd("mask", pif_pkg::MASK_OFS, 32'h0);
		rd("config", pif_pkg::CONFIG_OFS, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
	endtask

	// psp, adc, ssp, timer two, timer one: sticky with mask clear
	task automatic t_sticky;
		logic [10:0] src [5] = '{11'h400, 11'h200, 11'h010, 11'h002, 11'h001};
		logic [7:0]  fb  [5] = '{8'h80, 8'h40, 8'h08, 8'h02, 8'h01};
		for (int i = 0; i < 5; i++) begin
			pulse(src[i]);
			repeat (4) @(posedge ref_clk);
			chk("flag set", {24'h0, fb[i]}, {24'h0, flags});
			chk("irq masked", 32'h0, {31'h0, irq});
			bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
			chk("flag clear", 32'h0, {24'h0, flags});
		end
		rd("status", pif_pkg::STATUS_OFS, 32'hcb);
		rd("status again", pif_pkg::STATUS_OFS, 32'h0);
	endtask

	task automatic t_rxtx;
		pulse(11'h100);
		chk("rx full", 32'h20, {24'h0, flags});
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
		chk("rx ignores write", 32'h20, {24'h0, flags});
		pulse(11'h080);
		chk("rx read", 32'h0, {24'h0, flags});
		pulse(11'h040);
		chk("tx empty", 32'h10, {24'h0, flags});
		pulse(11'h020);
		chk("tx written", 32'h0, {24'h0, flags});
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h30);
		chk("rx tx ignore write", 32'h0, {24'h0, flags});
		bus(1'b0, pif_pkg::STATUS_OFS, 32'h0);
	endtask

	// every mode: only the matching unit event reaches bit 2
	task automatic t_ccp;
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, pif_pkg::CONFIG_OFS, 32'(m << 1));
			pulse(11'h008);
			chk("capture", {29'h0, (m == 1), 2'h0}, {24'h0, flags});
			bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
			pulse(11'h004);
			chk("compare", {29'h0, (m == 2), 2'h0}, {24'h0, flags});
			bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
		end
		bus(1'b1, pif_pkg::CONFIG_OFS, 32'h0);
		bus(1'b0, pif_pkg::STATUS_OFS, 32'h0);
	endtask

	task automatic t_small;
		bus(1'b1, pif_pkg::CONFIG_OFS, 32'h1);
		pulse(11'h400);
		chk("small psp event", 32'h0, {24'h0, flags});
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h80);
		rd("small psp write", pif_pkg::FLAGS_OFS, 32'h0);
		bus(1'b1, pif_pkg::CONFIG_OFS, 32'h0);
	endtask

	task automatic t_wr1;
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'hff);
		rd("write ones", pif_pkg::FLAGS_OFS, 32'hcf);
		rd("status untouched", pif_pkg::STATUS_OFS, 32'h0);
		be_val = 4'he;
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
		be_val = 4'hf;
		rd("lane off write", pif_pkg::FLAGS_OFS, 32'hcf);
		// the overflow reaches the flags in the very cycle the clearing write is taken
		fire <= 1'b1;
		pick <= pif_pkg::pif_evt_s'(11'h001);
		@(posedge ref_clk);
		fire <= 1'b0;
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
		chk("set beats clear", 32'h01, {24'h0, flags});
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
	endtask

	// clear first, then unmask, then raise and clear the interrupt
	task automatic t_irq;
		bus(1'b0, pif_pkg::STATUS_OFS, 32'h0);
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
		bus(1'b1, pif_pkg::MASK_OFS, 32'h01);
		chk("irq idle", 32'h0, {31'h0, irq});
		pulse(11'h002);
		chk("irq masked bit", 32'h0, {31'h0, irq});
		pulse(11'h001);
		chk("irq raised", 32'h1, {31'h0, irq});
		rd("status", pif_pkg::STATUS_OFS, 32'h03);
		chk("irq cleared", 32'h0, {31'h0, irq});
		chk("flags kept", 32'h03, {24'h0, flags});
		bus(1'b1, pif_pkg::FLAGS_OFS, 32'h0);
	endtask

	// ==================================================================
	// verdict and run control
	// ==================================================================
	task automatic final_report;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// the whole run is a few hundred cycles; this cuts a hung handshake
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("[ERR] watchdog expected done seen hang");
		final_report();
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_sticky();
		t_rxtx();
		t_ccp();
		t_small();
		t_wr1();
		t_irq();
		final_report();
	end
endmodule
